/* File: ext_module_reader.sv */
// Handshaked read engine copying extension module registers into a buffer
//
// Function
// RULE_01: Right positions 0 to 7 are accepted.
// RULE_02: Left positions 100 to 107 are accepted.
// RULE_03: Position outside both ranges raises error.
// RULE_04: Count must lie between 1 and 64.
// RULE_05: Start index within module's register range.
// RULE_06: Execute rise raises busy, active; done later.
// RULE_07: Busy and active high throughout transfer.
// RULE_08: Execute low drops done, zeroes buffer.
// RULE_09: Fault raises error, code; busy drops.
// RULE_10: Illegal input parameters also raise error.
// RULE_11: Error held until execute low, code cleared.
// RULE_12: Registers land at consecutive buffer elements.
// RULE_13: Values stored as signed 16 or 32.
// RULE_14: Parameters sampled at execute rise only.
// RULE_15: Right numbering counts only special modules.
// RULE_16: At most eight modules per side.
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module ext_module_reader
  import ext_reader_pkg::*;
#(
  parameter int SCAN_LEN = ext_reader_pkg::SCAN_CYCLES,
  parameter int DEPTH    = ext_reader_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Extension link
  output logic             ext_req,
  output logic             ext_left,
  output logic      [2:0]  ext_slot,
  output logic      [15:0] ext_index,
  input  wire logic [15:0] ext_max_index,
  input  wire logic [31:0] ext_rdata,
  input  wire logic        ext_ack,
  input  wire logic        ext_fault,
  // Transfer status
  output logic             busy,
  output logic             active,
  output logic             done,
  output logic             error,
  output logic      [15:0] fault_code
);
  import ext_reader_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // Software-visible configuration
  logic        ctrl_exec;
  logic        ctrl_wide;
  logic [7:0]  module_position;
  logic [15:0] module_register_index;
  logic [7:0]  reg_count;
  logic [7:0]  reg_base;

  // Bus data phase
  logic        dp_valid;
  logic        dp_write;
  logic [11:0] dp_addr;
  logic        dp_buffer;

  // Transfer engine
  engine_state_e state;
  logic          exec_q;
  logic          exec_rise;
  logic [7:0]    t_position;
  logic [15:0]   t_index;
  logic [7:0]    t_count;
  logic [7:0]    t_base;
  logic          t_wide;
  logic [7:0]    words_done;
  logic [AW-1:0] cur_addr;
  logic [AW-1:0] clr_addr;
  logic [AW-1:0] clr_last;
  logic [15:0]   check_fault;
  logic [31:0]   scan_cnt;
  logic          scan_tick;

  // Buffer ports
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0]   wr_data;
  logic [31:0]   buf_rdata;
  logic [31:0]   fitted;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Word-only slave; hsize is accepted but not decoded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 12'h000;
    end else if (hready) begin
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_addr  <= haddr[11:0];
    end
  end

  assign dp_buffer = (dp_addr[11:9] == BUF_WINDOW_TAG);

  // Configuration writes land at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_exec             <= 1'b0;
      ctrl_wide             <= 1'b0;
      module_position       <= RST_BYTE;
      module_register_index <= RST_HALF;
      reg_count             <= RST_BYTE;
      reg_base              <= RST_BYTE;
    end else if (dp_valid && dp_write) begin
      case (dp_addr)
        OFF_CONTROL: begin
          ctrl_exec <= hwdata[CTRL_EXEC_BIT];
          ctrl_wide <= hwdata[CTRL_WIDE_BIT];
        end
        OFF_POSITION: module_position       <= hwdata[7:0];
        OFF_START:    module_register_index <= hwdata[15:0];
        OFF_COUNT:    reg_count             <= hwdata[7:0];
        OFF_BASE:     reg_base              <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read mux; buffer data come from the memory's output register
  always_comb begin
    hrdata = RST_WORD;
    if (dp_valid && !dp_write) begin
      if (dp_buffer) begin
        hrdata = buf_rdata;
      end else begin
        case (dp_addr)
          OFF_CONTROL: begin
            hrdata[CTRL_EXEC_BIT] = ctrl_exec;
            hrdata[CTRL_WIDE_BIT] = ctrl_wide;
          end
          OFF_POSITION: hrdata[7:0]  = module_position;
          OFF_START:    hrdata[15:0] = module_register_index;
          OFF_COUNT:    hrdata[7:0]  = reg_count;
          OFF_BASE:     hrdata[7:0]  = reg_base;
          OFF_STATUS: begin
            hrdata[STAT_BUSY_BIT]                    = busy;
            hrdata[STAT_ACTIVE_BIT]                  = active;
            hrdata[STAT_DONE_BIT]                    = done;
            hrdata[STAT_ERROR_BIT]                   = error;
            hrdata[STAT_PROG_LSB+7:STAT_PROG_LSB]    = words_done;
          end
          OFF_FAULT: hrdata[15:0] = fault_code;
          default: hrdata = RST_WORD;
        endcase
      end
    end
  end

  // Free-running scan period; done waits for the next boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_cnt <= RST_WORD;
    end else if (scan_tick) begin
      scan_cnt <= RST_WORD;
    end else begin
      scan_cnt <= scan_cnt + 32'h0000_0001;
    end
  end

  assign scan_tick = (scan_cnt == 32'(SCAN_LEN - 1));

  // Execute edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exec_q <= 1'b0;
    end else begin
      exec_q <= ctrl_exec;
    end
  end

  assign exec_rise = ctrl_exec && !exec_q;

  reader_param_check #(
    .DEPTH           (DEPTH)
  ) u_check (
    .module_position (t_position),
    .start_index     (t_index),
    .count           (t_count),
    .dest_base       (t_base),
    .max_index       (ext_max_index),
    .fault           (check_fault)
  );

  // Parameter capture; later edits to the registers cannot disturb a run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t_position <= RST_BYTE;
      t_index    <= RST_HALF;
      t_count    <= RST_BYTE;
      t_base     <= RST_BYTE;
      t_wide     <= 1'b0;
      ext_left   <= 1'b0;
      ext_slot   <= 3'h0;
    end else if (state == ST_IDLE && exec_rise) begin
      t_position <= module_position; // see RULE_14
      t_index    <= module_register_index;
      t_count    <= reg_count;
      t_base     <= reg_base;
      t_wide     <= ctrl_wide;
      ext_left   <= pos_is_left(module_position); // see RULE_02
      // Digital-only modules take no slot, so the link counts only special ones
      ext_slot   <= pos_slot(module_position); // see RULE_01 see RULE_15
    end
  end

  // Main transfer sequence; a power-up sweep zeroes the whole buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= ST_CLEAR;
      clr_addr   <= '0;
      clr_last   <= AW'(DEPTH - 1);
      cur_addr   <= '0;
      ext_index  <= RST_HALF;
      words_done <= RST_BYTE;
      done       <= 1'b0;
      error      <= 1'b0;
      fault_code <= FAULT_NONE;
    end else begin
      case (state)
        ST_CLEAR: begin
          if (clr_addr == clr_last) begin
            state <= ST_IDLE;
          end else begin
            clr_addr <= clr_addr + AW'(1);
          end
        end
        ST_IDLE: begin
          // Further rises are ignored until the engine is back here
          if (exec_rise) begin
            state      <= ST_CHECK; // see RULE_06 see RULE_14
            words_done <= RST_BYTE;
          end
        end
        ST_CHECK: begin
          if (check_fault != FAULT_NONE) begin
            error      <= 1'b1; // see RULE_03 see RULE_10
            fault_code <= check_fault; // see RULE_09
            state      <= ST_HOLD;
          end else begin
            ext_index  <= t_index; // see RULE_05
            cur_addr   <= t_base[AW-1:0];
            state      <= ST_READ;
          end
        end
        ST_READ: begin
          if (ext_ack) begin
            if (ext_fault) begin
              error      <= 1'b1; // see RULE_09
              fault_code <= FAULT_LINK;
              state      <= ST_HOLD;
            end else begin
              ext_index  <= ext_index + 16'h0001;
              cur_addr   <= cur_addr + AW'(1); // see RULE_12
              words_done <= words_done + 8'h01;
              if (words_done == t_count - 8'h01) begin
                state <= ST_WAIT_SCAN; // see RULE_04
              end
            end
          end
        end
        ST_WAIT_SCAN: begin
          if (scan_tick) begin
            done  <= 1'b1; // see RULE_06
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Error and done stand until software drops execute
          if (!ctrl_exec) begin
            done       <= 1'b0; // see RULE_08
            error      <= 1'b0; // see RULE_11
            fault_code <= FAULT_NONE; // see RULE_11
            if (done || fault_code == FAULT_LINK) begin
              clr_addr <= t_base[AW-1:0]; // see RULE_08
              clr_last <= AW'(t_base + t_count - 8'h01);
              state    <= ST_CLEAR;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Busy and active share one window: entry on the rise, exit on done or error
  assign busy    = (state == ST_CHECK) || (state == ST_READ) || (state == ST_WAIT_SCAN); // see RULE_07
  assign active  = busy; // see RULE_06 see RULE_07
  assign ext_req = (state == ST_READ);

  // Narrow mode keeps the low half with its sign, as a 16-bit integer element
  assign fitted  = t_wide ? ext_rdata : {{16{ext_rdata[15]}}, ext_rdata[15:0]}; // see RULE_13

  assign wr_en   = (state == ST_CLEAR) || ((state == ST_READ) && ext_ack && !ext_fault);
  assign wr_addr = (state == ST_CLEAR) ? clr_addr : cur_addr; // see RULE_12
  assign wr_data = (state == ST_CLEAR) ? RST_WORD : fitted; // see RULE_08

  reader_buffer_ram #(
    .WIDTH   (32),
    .DEPTH   (DEPTH),
    .AW      (AW)
  ) u_buffer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (haddr[AW+1:2]),
    .rd_data (buf_rdata)
  );

endmodule : ext_module_reader

/* File: ext_reader_pkg.sv */
// Constants, types and helpers shared by the extension module register reader
package ext_reader_pkg;

  // Clock and scan timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int SCAN_PERIOD_NS  = 1_000_000;
  localparam int SCAN_CYCLES     = (SCAN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Byte offsets of the register map
  localparam logic [11:0] OFF_CONTROL    = 12'h000;
  localparam logic [11:0] OFF_POSITION   = 12'h004;
  localparam logic [11:0] OFF_START      = 12'h008;
  localparam logic [11:0] OFF_COUNT      = 12'h00C;
  localparam logic [11:0] OFF_BASE       = 12'h010;
  localparam logic [11:0] OFF_STATUS     = 12'h014;
  localparam logic [11:0] OFF_FAULT      = 12'h018;
  localparam logic [2:0]  BUF_WINDOW_TAG = 3'h1;

  // Field positions
  localparam int CTRL_EXEC_BIT   = 0;
  localparam int CTRL_WIDE_BIT   = 1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_DONE_BIT   = 2;
  localparam int STAT_ERROR_BIT  = 3;
  localparam int STAT_PROG_LSB   = 8;

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Legal parameter ranges
  localparam logic [7:0] POS_RIGHT_FIRST = 8'h00;
  localparam logic [7:0] POS_RIGHT_LAST  = 8'h07;
  localparam logic [7:0] POS_LEFT_FIRST  = 8'h64;
  localparam logic [7:0] POS_LEFT_LAST   = 8'h6B;
  localparam logic [7:0] COUNT_MIN       = 8'h01;
  localparam logic [7:0] COUNT_MAX       = 8'h40;
  localparam int         BUF_DEPTH       = 128;

  // Fault codes
  localparam logic [15:0] FAULT_NONE     = 16'h0000;
  localparam logic [15:0] FAULT_POSITION = 16'h0001;
  localparam logic [15:0] FAULT_COUNT    = 16'h0002;
  localparam logic [15:0] FAULT_INDEX    = 16'h0003;
  localparam logic [15:0] FAULT_BASE     = 16'h0004;
  localparam logic [15:0] FAULT_LINK     = 16'h0005;

  typedef enum {ST_CLEAR, ST_IDLE, ST_CHECK, ST_READ, ST_WAIT_SCAN, ST_HOLD} engine_state_e;

  function automatic logic pos_is_left(input logic [7:0] pos);
    return (pos >= POS_LEFT_FIRST) && (pos <= POS_LEFT_LAST);
  endfunction : pos_is_left

  function automatic logic pos_is_right(input logic [7:0] pos);
    return (pos >= POS_RIGHT_FIRST) && (pos <= POS_RIGHT_LAST);
  endfunction : pos_is_right

  function automatic logic [2:0] pos_slot(input logic [7:0] pos);
    logic [7:0] rel;
    rel = pos_is_left(pos) ? (pos - POS_LEFT_FIRST) : pos;
    return rel[2:0];
  endfunction : pos_slot

endpackage : ext_reader_pkg

/* File: reader_buffer_ram.sv */
// Destination buffer memory with registered read port
`timescale 1ns/10ps
module reader_buffer_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 128,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : reader_buffer_ram

/* File: reader_param_check.sv */
// Legality check of the parameters of one register transfer
`timescale 1ns/10ps
module reader_param_check
  import ext_reader_pkg::*;
#(
  parameter int DEPTH = 128
) (
  // Sampled transfer parameters
  input  wire logic [7:0]  module_position,
  input  wire logic [15:0] start_index,
  input  wire logic [7:0]  count,
  input  wire logic [7:0]  dest_base,
  // Highest index of the addressed module
  input  wire logic [15:0] max_index,
  // Result
  output logic      [15:0] fault
);
  logic [16:0] last_index;
  logic [8:0]  end_slot;

  always_comb begin
    last_index = {1'b0, start_index} + {9'h000, count} - 17'h0_0001;
    end_slot   = {1'b0, dest_base} + {1'b0, count};
    if (!pos_is_left(module_position) && !pos_is_right(module_position)) begin
      fault = FAULT_POSITION; // see RULE_03
    end else if (count < COUNT_MIN || count > COUNT_MAX) begin
      fault = FAULT_COUNT; // see RULE_04
    end else if (last_index > {1'b0, max_index}) begin
      fault = FAULT_INDEX; // see RULE_05
    end else if (end_slot > 9'(DEPTH)) begin
      fault = FAULT_BASE;
    end else begin
      fault = FAULT_NONE;
    end
  end
endmodule : reader_param_check

/* File: ext_module_reader_monitor.sv */
// Concurrent checks on the ports of the extension module reader
`timescale 1ns/10ps
module ext_module_reader_monitor
  import ext_reader_pkg::*;
#(
  parameter int SCAN_LEN = 16,
  parameter int DEPTH    = 128
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Extension link
  input wire logic        ext_req,
  input wire logic [15:0] ext_index,
  input wire logic        ext_ack,
  input wire logic        ext_fault,
  // Transfer status
  input wire logic        busy,
  input wire logic        active,
  input wire logic        done,
  input wire logic        error,
  input wire logic [15:0] fault_code
);
  logic wr_ctl;
  logic exec_q;

  // Execute lives in a register, so mirror it from the bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_ctl <= 1'b0;
    else if (hready) wr_ctl <= hsel && htrans[1] && hwrite && (haddr[11:0] == OFF_CONTROL);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) exec_q <= 1'b0;
    else if (hready && wr_ctl) exec_q <= hwdata[CTRL_EXEC_BIT];
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_busy_active_pair: assert property (busy == active)
    else $error("busy and active differ");
  chk_exec_starts_busy: assert property ($rose(exec_q) && !busy && !done && !error |-> ##[1:3] busy)
    else $error("execute rise did not start a transfer");
  chk_done_ends_busy: assert property ($rose(done) |-> $past(busy) && !busy && !error)
    else $error("done rose without busy falling");
  chk_error_ends_busy: assert property ($rose(error) |-> $past(busy) && !busy && fault_code != FAULT_NONE)
    else $error("error rose without code or busy fall");
  chk_error_holds: assert property (error && exec_q |=> error)
    else $error("error dropped while execute high");
  chk_fault_cleared: assert property ($fell(error) |-> fault_code == FAULT_NONE && !exec_q)
    else $error("fault code kept after error fell");
  chk_done_holds: assert property (done && exec_q |=> done)
    else $error("done dropped while execute high");
  chk_done_clears: assert property (done && !exec_q |-> ##[1:3] !done)
    else $error("done stayed after execute low");
  chk_req_in_busy: assert property (ext_req |-> busy && !done && !error)
    else $error("link request outside a transfer");
  chk_index_steps: assert property (ext_req && ext_ack && !ext_fault |=> ext_index == $past(ext_index) + 16'h0001)
    else $error("register index did not advance");
  chk_link_fault: assert property (ext_req && ext_ack && ext_fault |-> ##[1:2] error && fault_code == FAULT_LINK)
    else $error("link fault not reported");
  chk_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule : ext_module_reader_monitor

bind ext_module_reader ext_module_reader_monitor #(.SCAN_LEN(SCAN_LEN), .DEPTH(DEPTH)) mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .ext_req(ext_req),
  .ext_index(ext_index), .ext_ack(ext_ack), .ext_fault(ext_fault), .busy(busy), .active(active),
  .done(done), .error(error), .fault_code(fault_code));

/* File: ext_partner.sv */
// Behavioural set of extension modules answering register reads
`timescale 1ns/10ps
module ext_partner #(
  parameter logic [15:0] MAX_IDX = 16'h0063
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Link from the reader
  input  wire logic        ext_req,
  input  wire logic        ext_left,
  input  wire logic [2:0]  ext_slot,
  input  wire logic [15:0] ext_index,
  output logic      [15:0] ext_max_index,
  output logic      [31:0] ext_rdata,
  output logic             ext_ack,
  output logic             ext_fault,
  // Fault injection
  input  wire logic [15:0] fault_index
);
  logic [1:0] wait_cnt;

  // Same top index on every slot; three slot bits cap each side at eight
  assign ext_max_index = MAX_IDX;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_ack   <= 1'b0;
      ext_fault <= 1'b0;
      ext_rdata <= 32'h0000_0000;
      wait_cnt  <= 2'h0;
    end else if (ext_ack || !ext_req) begin
      // One-cycle ack lets the index move before the next word
      ext_ack   <= 1'b0;
      ext_fault <= 1'b0;
      ext_rdata <= ~ext_rdata;
      wait_cnt  <= 2'($urandom_range(0, 2));
    end else if (wait_cnt != 2'h0) begin
      wait_cnt  <= wait_cnt - 2'h1;
      ext_rdata <= ~ext_rdata;
    end else begin
      ext_ack   <= 1'b1;
      ext_fault <= (ext_index == fault_index);
      ext_rdata <= {8'h5A, 4'h0, ext_left, ext_slot, 16'h8000 ^ ext_index};
    end
  end
endmodule : ext_partner

/* File: ext_module_reader_bench.sv */
// Self-checking bench of the extension module register reader
`timescale 1ns/10ps
module ext_module_reader_bench;
  import ext_reader_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, rd_ph, hreadyout, hresp;
  logic        ext_req, ext_left, ext_ack, ext_fault, busy, active, done, error;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ext_slot;
  logic [31:0] haddr, hwdata, hrdata, ext_rdata;
  logic [15:0] ext_index, ext_max_index, fault_code, fault_index;
  logic [31:0] exp_q[$];
  string       nm_q[$];
  int          fails, num_checks;

  ext_module_reader #(.SCAN_LEN(16), .DEPTH(128)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_req(ext_req), .ext_left(ext_left), .ext_slot(ext_slot), .ext_index(ext_index),
    .ext_max_index(ext_max_index), .ext_rdata(ext_rdata), .ext_ack(ext_ack), .ext_fault(ext_fault),
    .busy(busy), .active(active), .done(done), .error(error), .fault_code(fault_code));

  ext_partner p (
    .hclk(hclk), .hresetn(hresetn), .ext_req(ext_req), .ext_left(ext_left), .ext_slot(ext_slot),
    .ext_index(ext_index), .ext_max_index(ext_max_index), .ext_rdata(ext_rdata), .ext_ack(ext_ack),
    .ext_fault(ext_fault), .fault_index(fault_index));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph  <= !wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph  <= 1'b0;
  endtask : ahb

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    ahb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Read data is taken at the edge closing the data phase
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) check(nm_q.pop_front(), hrdata, exp_q.pop_front());
  end

  function automatic logic [31:0] pdata(input logic [7:0] pos, input logic [15:0] idx, input logic wide);
    logic [7:0]  s;
    logic [31:0] w;
    s = (pos >= 8'd100) ? pos - 8'd100 : pos;
    w = {8'h5A, 4'h0, pos >= 8'd100, s[2:0], 16'h8000 ^ idx};
    return wide ? w : {{16{w[15]}}, w[15:0]};
  endfunction : pdata

  task automatic go(input logic [7:0] pos, input logic [15:0] st, input logic [7:0] n, input logic [7:0] b,
                    input logic wide, input logic [15:0] f);
    int i;
    ahb(1'b1, OFF_POSITION, {24'h00_0000, pos});
    ahb(1'b1, OFF_START, {16'h0000, st});
    ahb(1'b1, OFF_COUNT, {24'h00_0000, n});
    ahb(1'b1, OFF_BASE, {24'h00_0000, b});
    ahb(1'b1, OFF_CONTROL, {30'h0000_0000, wide, 1'b1});
    ahb(1'b1, OFF_POSITION, {24'h00_0000, ~pos});
    for (i = 0; i < 3000 && done !== 1'b1 && error !== 1'b1; i++) @(posedge hclk);
    rd("fault", OFF_FAULT, {16'h0000, f});
    rd("status", OFF_STATUS, (f == FAULT_NONE) ? {16'h0000, n, 8'h04} : 32'h0000_0008);
    for (i = 0; i < n && f == FAULT_NONE; i++)
      rd("elem", 12'h200 + 12'(4 * (b + i)), pdata(pos, st + 16'(i), wide));
    ahb(1'b1, OFF_CONTROL, 32'h0000_0000);
    repeat (n + 12) @(posedge hclk);
    check("flags", {29'h0, done, error, busy}, 32'h0000_0000);
    rd("fault clr", OFF_FAULT, 32'h0000_0000);
    if (f == FAULT_NONE) rd("elem clr", 12'h200 + 12'(4 * b), 32'h0000_0000);
  endtask : go

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // Longest path is well under a tenth of this span
  initial begin
    repeat (60000) @(posedge hclk);
    fails++;
    conclude();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = 32'h0; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; rd_ph = 1'b0; fault_index = 16'hFFFF;
    fails = 0;
    num_checks = 0;
    void'($urandom(58150));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // Clear sweep after reset hides execute edges
    repeat (140) @(posedge hclk);
    rd("unmapped", 12'h100, 32'h0000_0000);
    rd("status rst", OFF_STATUS, 32'h0000_0000);
    go(8'd100, 16'd2, 8'd4, 8'd1, 1'b0, FAULT_NONE);
    go(8'd107, 16'($urandom_range(0, 99)), 8'd1, 8'd127, 1'b1, FAULT_NONE);
    go(8'd7, 16'($urandom_range(0, 36)), 8'd64, 8'd64, 1'b0, FAULT_NONE);
    go(8'd0, 16'd99, 8'd1, 8'd0, 1'b1, FAULT_NONE);
    go(8'd8, 16'd0, 8'd1, 8'd0, 1'b0, FAULT_POSITION);
    go(8'd99, 16'd0, 8'd1, 8'd0, 1'b0, FAULT_POSITION);
    go(8'd108, 16'd0, 8'd1, 8'd0, 1'b0, FAULT_POSITION);
    go(8'd0, 16'd0, 8'd0, 8'd0, 1'b0, FAULT_COUNT);
    go(8'd101, 16'd0, 8'd65, 8'd0, 1'b0, FAULT_COUNT);
    go(8'd2, 16'd99, 8'd2, 8'd0, 1'b0, FAULT_INDEX);
    go(8'd2, 16'd0, 8'd64, 8'd65, 1'b0, FAULT_BASE);
    fault_index <= 16'd5;
    go(8'd3, 16'd5, 8'd3, 8'd0, 1'b0, FAULT_LINK);
    conclude();
  end
endmodule : ext_module_reader_bench
